// File: rx_eq_pkg.sv
// Constants, field layout and carrier types for the receive-port equalizer control
package rx_eq_pkg;

  // Register offsets on the serial control bus
  localparam logic [7:0] ADDR_LINK_DEBUG = 8'hd0;
  localparam logic [7:0] ADDR_ADAPT_CTRL = 8'hd2;
  localparam logic [7:0] ADDR_EQ_STATUS = 8'hd3;
  localparam logic [7:0] ADDR_BYPASS_SEL = 8'hd4;
  localparam logic [7:0] ADDR_EQ_LIMITS = 8'hd5;

  // Link debug register fields
  localparam int DBG_SINGLE_ERR_BIT = 0;
  localparam int DBG_CONT_ERR_BIT = 1;
  localparam int DBG_RSVD_LO_LSB = 2;
  localparam int DBG_RSVD_LO_MSB = 4;
  localparam int DBG_SELFTEST_BIT = 5;
  localparam int DBG_RSVD_HI_LSB = 6;
  localparam int DBG_RSVD_HI_MSB = 7;

  // Adapt control register fields
  localparam int CTL_FLOOR_EN_BIT = 2;
  localparam int CTL_RESTART_BIT = 3;
  localparam int CTL_FIRST_LOCK_BIT = 4;
  localparam int CTL_RELOCK_LSB = 5;
  localparam int CTL_RELOCK_MSB = 7;

  // Status register fields
  localparam int STS_B_LSB = 0;
  localparam int STS_B_MSB = 2;
  localparam int STS_A_LSB = 3;
  localparam int STS_A_MSB = 5;

  // Bypass / manual select register fields
  localparam int BYP_DISABLE_BIT = 0;
  localparam int BYP_LOWER_LSB = 1;
  localparam int BYP_LOWER_MSB = 3;
  localparam int BYP_LOCK_MODE_BIT = 4;
  localparam int BYP_UPPER_LSB = 5;
  localparam int BYP_UPPER_MSB = 7;

  // Limit register fields
  localparam int LIM_FLOOR_LSB = 0;
  localparam int LIM_FLOOR_MSB = 3;
  localparam int LIM_CEIL_LSB = 4;
  localparam int LIM_CEIL_MSB = 7;

  // Reset values and the search step
  localparam logic [2:0] RELOCK_RESET = 3'h4;
  localparam logic [2:0] UPPER_RESET = 3'h3;
  localparam logic [2:0] LOWER_RESET = 3'h0;
  localparam logic [3:0] CEIL_RESET = 4'hf;
  localparam logic [3:0] FLOOR_RESET = 4'h8;
  localparam logic [3:0] SETTING_ZERO = 4'h0;
  localparam logic [3:0] SETTING_STEP = 4'h1;
  localparam logic [7:0] READ_ZERO = 8'h00;

  // Relock timing: shortest code, doubled per code step
  localparam int CLK_PERIOD_NS = 100;
  localparam int RELOCK_BASE_NS = 164000;
  localparam int RELOCK_BASE_CYCLES = (RELOCK_BASE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int RELOCK_CNT_W = 18;

  // Software-held equalizer configuration
  typedef struct packed {
    logic [2:0] relock_code;
    logic first_lock_from_zero;
    logic floor_start_enable;
    logic lock_needs_adapt_done;
    logic equalizer_adapt_disable;
    logic [2:0] manual_select_upper;
    logic [2:0] manual_select_lower;
    logic [3:0] equalizer_ceiling;
    logic [3:0] equalizer_floor_setting;
  } eq_cfg_t;

  // Adaptation states, Gray coded along the search path
  typedef enum logic [2:0] {
    ST_BYPASS = 3'b000,
    ST_START = 3'b001,
    ST_SEARCH = 3'b011,
    ST_LOCKED = 3'b010
  } eq_state_t;

endpackage : rx_eq_pkg

// File: eq_relock_timer.sv
// Relock wait timer: expires after the base time scaled by two to the code
`timescale 1ns/10ps
`default_nettype none
module eq_relock_timer #(
  parameter int BASE_CYCLES = rx_eq_pkg::RELOCK_BASE_CYCLES,
  parameter int CNT_W = rx_eq_pkg::RELOCK_CNT_W
) (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic rstn,
  // Control
  input wire logic clear,
  input wire logic [2:0] code,
  // Result
  output logic expire
);
  import rx_eq_pkg::*;

  logic [CNT_W-1:0] count_q;
  logic [CNT_W-1:0] count_d;
  logic [CNT_W-1:0] limit;
  logic at_limit;

  // Limit shifts the base count left by the code, so each code doubles the wait
  // Last count of the wait is one less than base shifted by code, so the period is exactly base times two to the code
  assign limit = (CNT_W'(BASE_CYCLES) << code) - CNT_W'(1);
  assign at_limit = (count_q >= limit);
  assign expire = at_limit & ~clear;
  assign count_d = (clear | at_limit) ? '0 : count_q + CNT_W'(1);

  // Free-running count, wrapping itself at the limit and restarted by the caller's clear
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      count_q <= '0;
    end else begin
      count_q <= count_d;
    end
  end

endmodule : eq_relock_timer
`default_nettype wire

// File: rx_equalizer_adapt_control.sv
// Receive-port equalizer adaptation control, status and back-channel error injection
`timescale 1ns/10ps
`default_nettype none
// Contract
// RULE_01 - Debug bit 5 mirrors remote self-test, read-only
// RULE_02 - Continuous error bit corrupts every back-channel frame
// RULE_03 - Single error bit corrupts one frame, self-clears
// RULE_04 - Relock wait doubles per code, reset code 4
// RULE_05 - First-lock mode restarts adaptation from zero
// RULE_06 - Restart bit restarts adaptation, self-clears
// RULE_07 - Floor-start begins adaptation at floor value
// RULE_08 - Two read-only 3-bit status codes
// RULE_09 - Bypass drives upper select from stage-one field
// RULE_10 - Bypass drives lower select from stage-two field
// RULE_11 - Lock qualification requires adaptation complete
// RULE_12 - Bypass bit disables adaptation, manual selects used
// RULE_13 - Adaptation never exceeds ceiling field
// RULE_14 - Floor field, reset 8, supplies start setting
// RULE_15 - Timeout at ceiling wraps back to start
module rx_equalizer_adapt_control #(
  parameter int RELOCK_BASE_CYCLES = rx_eq_pkg::RELOCK_BASE_CYCLES
) (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic rstn,
  // Register port from the serial control bus decoder
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  output logic [7:0] reg_rdata,
  // Link status from the receiver front end (asynchronous)
  input wire logic remote_selftest_in,
  input wire logic cdr_lock_in,
  // Back channel transmitter
  input wire logic bc_frame_start,
  output logic bc_frame_corrupt,
  // Equalizer control and lock report
  output logic [5:0] eq_select,
  output logic adapt_done,
  output logic rx_lock
);
  import rx_eq_pkg::*;

  // Two-flop synchronisers for selftest (bit 0) and lock (bit 1)
  logic [1:0] async_in;
  logic [1:0] sync1_q;
  logic [1:0] sync2_q;
  assign async_in = {cdr_lock_in, remote_selftest_in};

  genvar gi;
  generate
    for (gi = 0; gi < 2; gi++) begin : g_sync
      always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
          sync1_q[gi] <= 1'b0;
          sync2_q[gi] <= 1'b0;
        end else begin
          sync1_q[gi] <= async_in[gi];
          sync2_q[gi] <= sync1_q[gi];
        end
      end
    end
  endgenerate

  logic selftest_s;
  logic lock_s;
  assign selftest_s = sync2_q[0];
  assign lock_s = sync2_q[1];

  // Register write decode
  logic wr_dbg;
  logic wr_ctl;
  logic wr_byp;
  logic wr_lim;
  assign wr_dbg = reg_wr & (reg_addr == ADDR_LINK_DEBUG);
  assign wr_ctl = reg_wr & (reg_addr == ADDR_ADAPT_CTRL);
  assign wr_byp = reg_wr & (reg_addr == ADDR_BYPASS_SEL);
  assign wr_lim = reg_wr & (reg_addr == ADDR_EQ_LIMITS);

  logic restart_req;
  logic single_err_req;
  assign restart_req = wr_ctl & reg_wdata[CTL_RESTART_BIT];
  assign single_err_req = wr_dbg & reg_wdata[DBG_SINGLE_ERR_BIT];

  // Configuration and debug storage
  eq_cfg_t cfg_q;
  logic cont_err_q;
  logic single_err_q;
  logic [4:0] dbg_rsvd_q;
  logic single_used;

  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      cfg_q.relock_code <= RELOCK_RESET;
      cfg_q.first_lock_from_zero <= 1'b0;
      cfg_q.floor_start_enable <= 1'b0;
      cfg_q.lock_needs_adapt_done <= 1'b0;
      cfg_q.equalizer_adapt_disable <= 1'b0;
      cfg_q.manual_select_upper <= UPPER_RESET;
      cfg_q.manual_select_lower <= LOWER_RESET;
      cfg_q.equalizer_ceiling <= CEIL_RESET; // [RULE_13]
      cfg_q.equalizer_floor_setting <= FLOOR_RESET; // [RULE_14]
    end else begin
      if (wr_ctl) begin
        cfg_q.relock_code <= reg_wdata[CTL_RELOCK_MSB:CTL_RELOCK_LSB];
        cfg_q.first_lock_from_zero <= reg_wdata[CTL_FIRST_LOCK_BIT];
        cfg_q.floor_start_enable <= reg_wdata[CTL_FLOOR_EN_BIT];
      end
      if (wr_byp) begin
        cfg_q.manual_select_upper <= reg_wdata[BYP_UPPER_MSB:BYP_UPPER_LSB];
        cfg_q.lock_needs_adapt_done <= reg_wdata[BYP_LOCK_MODE_BIT];
        cfg_q.manual_select_lower <= reg_wdata[BYP_LOWER_MSB:BYP_LOWER_LSB];
        cfg_q.equalizer_adapt_disable <= reg_wdata[BYP_DISABLE_BIT];
      end
      if (wr_lim) begin
        cfg_q.equalizer_ceiling <= reg_wdata[LIM_CEIL_MSB:LIM_CEIL_LSB];
        cfg_q.equalizer_floor_setting <= reg_wdata[LIM_FLOOR_MSB:LIM_FLOOR_LSB];
      end
    end
  end

  // Single error is spent on the next frame start; a new write wins over the spend
  assign single_used = bc_frame_start & single_err_q;

  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      cont_err_q <= 1'b0;
      single_err_q <= 1'b0;
      dbg_rsvd_q <= '0;
    end else begin
      if (wr_dbg) begin
        cont_err_q <= reg_wdata[DBG_CONT_ERR_BIT];
        dbg_rsvd_q <= {reg_wdata[DBG_RSVD_HI_MSB:DBG_RSVD_HI_LSB], reg_wdata[DBG_RSVD_LO_MSB:DBG_RSVD_LO_LSB]};
      end
      single_err_q <= single_err_req | (single_err_q & ~single_used); // [RULE_03]
    end
  end

  // Corruption flag marks the frame that starts in the previous cycle
  logic bc_corrupt_q;
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      bc_corrupt_q <= 1'b0;
    end else begin
      bc_corrupt_q <= bc_frame_start & (cont_err_q | single_err_q); // [RULE_02] [RULE_03]
    end
  end
  assign bc_frame_corrupt = bc_corrupt_q;

  // Adaptation state machine
  eq_state_t state_q;
  eq_state_t state_d;
  logic [3:0] setting_q;
  logic [3:0] setting_d;
  logic first_seen_q;
  logic first_seen_d;
  logic timer_clear;
  logic timer_expire;
  logic [3:0] start_value;
  logic [3:0] start_clamped;
  logic at_ceiling;

  assign start_value = cfg_q.floor_start_enable ? cfg_q.equalizer_floor_setting : SETTING_ZERO; // [RULE_07] [RULE_14]
  // A floor above the ceiling is held at the ceiling rather than overshooting
  assign start_clamped = (start_value > cfg_q.equalizer_ceiling) ? cfg_q.equalizer_ceiling : start_value; // [RULE_13]
  assign at_ceiling = (setting_q >= cfg_q.equalizer_ceiling);

  always_comb begin
    state_d = state_q;
    setting_d = setting_q;
    first_seen_d = first_seen_q;
    timer_clear = 1'b0;
    if (cfg_q.equalizer_adapt_disable) begin
      state_d = ST_BYPASS; // [RULE_12]
      timer_clear = 1'b1;
    end else if (restart_req) begin
      state_d = ST_START; // [RULE_06]
      timer_clear = 1'b1;
    end else begin
      case (state_q)
        ST_BYPASS: begin
          state_d = ST_START;
          timer_clear = 1'b1;
        end
        ST_START: begin
          setting_d = start_clamped;
          state_d = ST_SEARCH;
          timer_clear = 1'b1;
        end
        ST_SEARCH: begin
          if (lock_s && cfg_q.first_lock_from_zero && !first_seen_q) begin
            // First lock forces a fresh search from zero for a repeatable result
            first_seen_d = 1'b1;
            setting_d = SETTING_ZERO; // [RULE_05]
            timer_clear = 1'b1;
          end else if (lock_s) begin
            first_seen_d = 1'b1;
            state_d = ST_LOCKED;
            timer_clear = 1'b1;
          end else if (timer_expire) begin
            if (at_ceiling) begin
              setting_d = start_clamped; // [RULE_15] [RULE_13]
            end else begin
              setting_d = setting_q + SETTING_STEP; // [RULE_04]
            end
          end
        end
        ST_LOCKED: begin
          if (!lock_s) begin
            state_d = ST_SEARCH;
            timer_clear = 1'b1;
          end
        end
        default: begin
          state_d = ST_START;
          timer_clear = 1'b1;
        end
      endcase
    end
  end

  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      state_q <= ST_START;
      setting_q <= SETTING_ZERO;
      first_seen_q <= 1'b0;
    end else begin
      state_q <= state_d;
      setting_q <= setting_d;
      first_seen_q <= first_seen_d;
    end
  end

  // Relock wait per setting, selected by the 3-bit code
  eq_relock_timer #(
    .BASE_CYCLES(RELOCK_BASE_CYCLES),
    .CNT_W(RELOCK_CNT_W)
  ) u_relock_timer (
    .clk_sys(clk_sys),
    .rstn(rstn),
    .clear(timer_clear),
    .code(cfg_q.relock_code), // [RULE_04]
    .expire(timer_expire)
  );

  // Select outputs: manual fields in bypass, search setting otherwise
  logic [5:0] select_d;
  logic [5:0] select_q;
  logic done_q;
  assign select_d = cfg_q.equalizer_adapt_disable ?
                    {cfg_q.manual_select_upper, cfg_q.manual_select_lower} : // [RULE_09] [RULE_10] [RULE_12]
                    {2'b00, setting_q};

  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      select_q <= '0;
      done_q <= 1'b0;
    end else begin
      select_q <= select_d;
      done_q <= (state_d == ST_LOCKED) | (state_d == ST_BYPASS);
    end
  end
  assign eq_select = select_q;
  assign adapt_done = done_q;

  // Reported lock, optionally qualified by finished adaptation
  logic lock_q;
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      lock_q <= 1'b0;
    end else begin
      lock_q <= cfg_q.lock_needs_adapt_done ? (lock_s & done_q) : lock_s; // [RULE_11]
    end
  end
  assign rx_lock = lock_q;

  // Read mux; restart bit always reads zero since it never stores
  logic [7:0] dbg_rd;
  logic [7:0] ctl_rd;
  logic [7:0] sts_rd;
  logic [7:0] byp_rd;
  logic [7:0] lim_rd;
  logic [7:0] rdata_d;
  logic [7:0] rdata_q;

  always_comb begin
    dbg_rd = READ_ZERO;
    dbg_rd[DBG_RSVD_HI_MSB:DBG_RSVD_HI_LSB] = dbg_rsvd_q[4:3];
    dbg_rd[DBG_SELFTEST_BIT] = selftest_s; // [RULE_01]
    dbg_rd[DBG_RSVD_LO_MSB:DBG_RSVD_LO_LSB] = dbg_rsvd_q[2:0];
    dbg_rd[DBG_CONT_ERR_BIT] = cont_err_q;
    dbg_rd[DBG_SINGLE_ERR_BIT] = single_err_q;
    ctl_rd = READ_ZERO;
    ctl_rd[CTL_RELOCK_MSB:CTL_RELOCK_LSB] = cfg_q.relock_code;
    ctl_rd[CTL_FIRST_LOCK_BIT] = cfg_q.first_lock_from_zero;
    ctl_rd[CTL_FLOOR_EN_BIT] = cfg_q.floor_start_enable;
    sts_rd = READ_ZERO;
    sts_rd[STS_A_MSB:STS_A_LSB] = state_q; // [RULE_08]
    sts_rd[STS_B_MSB:STS_B_LSB] = setting_q[3:1]; // [RULE_08]
    byp_rd = READ_ZERO;
    byp_rd[BYP_UPPER_MSB:BYP_UPPER_LSB] = cfg_q.manual_select_upper;
    byp_rd[BYP_LOCK_MODE_BIT] = cfg_q.lock_needs_adapt_done;
    byp_rd[BYP_LOWER_MSB:BYP_LOWER_LSB] = cfg_q.manual_select_lower;
    byp_rd[BYP_DISABLE_BIT] = cfg_q.equalizer_adapt_disable;
    lim_rd = {cfg_q.equalizer_ceiling, cfg_q.equalizer_floor_setting};
    case (reg_addr)
      ADDR_LINK_DEBUG: rdata_d = dbg_rd;
      ADDR_ADAPT_CTRL: rdata_d = ctl_rd;
      ADDR_EQ_STATUS: rdata_d = sts_rd;
      ADDR_BYPASS_SEL: rdata_d = byp_rd;
      ADDR_EQ_LIMITS: rdata_d = lim_rd;
      default: rdata_d = READ_ZERO;
    endcase
  end

  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      rdata_q <= READ_ZERO;
    end else begin
      rdata_q <= rdata_d;
    end
  end
  assign reg_rdata = rdata_q;

endmodule : rx_equalizer_adapt_control
`default_nettype wire

// File: rx_eq_checker.sv
// Port-level assertions for the receive-port equalizer control
`timescale 1ns/10ps
`default_nettype none
module rx_eq_checker #(
  parameter int RELOCK_BASE_CYCLES = 4
) (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic rstn,
  // Register port
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic [7:0] reg_rdata,
  // Link and back channel
  input wire logic remote_selftest_in,
  input wire logic cdr_lock_in,
  input wire logic bc_frame_start,
  input wire logic bc_frame_corrupt,
  // Equalizer
  input wire logic [5:0] eq_select,
  input wire logic adapt_done,
  input wire logic rx_lock
);
  import rx_eq_pkg::*;
  logic [7:0] byp_q;
  logic [7:0] lim_q;
  logic cont_q;
  logic [2:0] age_q;
  // Write decodes and settle qualifiers
  wire logic wr_byp = reg_wr && reg_addr == ADDR_BYPASS_SEL;
  wire logic wr_lim = reg_wr && reg_addr == ADDR_EQ_LIMITS;
  wire logic wr_dbg = reg_wr && reg_addr == ADDR_LINK_DEBUG;
  wire logic [2:0] age_d = reg_wr ? 3'h0 : (age_q == 3'h7 ? age_q : age_q + 3'h1);
  wire logic settled = age_q >= 3'h4; // Outputs lag a write by a few cycles
  wire logic byp = byp_q[BYP_DISABLE_BIT];
  // Shadow of the bypass, limit and continuous-error fields, age counts quiet cycles since a write
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      byp_q <= 8'h60;
      lim_q <= 8'hf8;
      cont_q <= 1'h0;
      age_q <= 3'h0;
    end else begin
      byp_q <= wr_byp ? reg_wdata : byp_q;
      lim_q <= wr_lim ? reg_wdata : lim_q;
      cont_q <= wr_dbg ? reg_wdata[DBG_CONT_ERR_BIT] : cont_q;
      age_q <= age_d;
    end
  end
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rstn);
  property p_cont; bc_frame_start && cont_q |=> bc_frame_corrupt; endproperty
  a_cont: assert property (p_cont) else $error("frame not corrupted");
  property p_idle; !bc_frame_start |=> !bc_frame_corrupt; endproperty
  a_idle: assert property (p_idle) else $error("corrupt without frame");
  property p_upper; settled && byp |-> eq_select[5:3] == byp_q[7:5]; endproperty
  a_upper: assert property (p_upper) else $error("upper select wrong");
  property p_lower; settled && byp |-> eq_select[2:0] == byp_q[3:1]; endproperty
  a_lower: assert property (p_lower) else $error("lower select wrong");
  property p_bdone; settled && byp |-> adapt_done; endproperty
  a_bdone: assert property (p_bdone) else $error("bypass not done");
  property p_pad; settled && !byp |-> eq_select[5:4] == 2'h0; endproperty
  a_pad: assert property (p_pad) else $error("select pad wrong");
  property p_ceil; settled && !byp |-> eq_select[3:0] <= lim_q[7:4]; endproperty
  a_ceil: assert property (p_ceil) else $error("above ceiling");
  property p_qual; settled && byp_q[BYP_LOCK_MODE_BIT] && rx_lock |-> $past(adapt_done); endproperty
  a_qual: assert property (p_qual) else $error("lock before adapt done");
  property p_ro; $past(reg_addr) == ADDR_EQ_STATUS |-> reg_rdata[7:6] == 2'h0; endproperty
  a_ro: assert property (p_ro) else $error("status pad nonzero");
  property p_sc; $past(reg_addr) == ADDR_ADAPT_CTRL |-> {reg_rdata[3], reg_rdata[1:0]} == 3'h0; endproperty
  a_sc: assert property (p_sc) else $error("restart reads one");
  property p_lim; $past(reg_addr) == ADDR_EQ_LIMITS && age_q >= 3'h2 |-> reg_rdata == lim_q; endproperty
  a_lim: assert property (p_lim) else $error("limit readback wrong");
  // Main scenarios reached
  c_corrupt: cover property (bc_frame_corrupt);
  c_locked: cover property (rx_lock && adapt_done && !byp);
  c_bypass: cover property (settled && byp && adapt_done);
endmodule : rx_eq_checker
`default_nettype wire

// File: remote_ser_model.sv
// Remote serializer stand-in: lock and self-test levels, back-channel frame tally
`timescale 1ns/10ps
`default_nettype none
module remote_ser_model #(
  parameter int LOCK_DELAY = 3
) (
  // Clock and commands
  input wire logic clk_sys,
  input wire logic want_lock,
  input wire logic want_selftest,
  // Link status pins
  output logic remote_selftest_in,
  output logic cdr_lock_in,
  // Back channel as received
  input wire logic bc_frame_corrupt,
  output logic [7:0] bad_frames
);
  int wait_q = 0;
  initial begin
    remote_selftest_in = 1'h0;
    cdr_lock_in = 1'h0;
    bad_frames = 8'h00;
  end
  // Levels change off the clock phase, since the link is asynchronous
  always @(posedge clk_sys) begin
    wait_q <= want_lock ? wait_q + 1 : 0;
    cdr_lock_in <= #37 want_lock && wait_q >= LOCK_DELAY;
    remote_selftest_in <= #23 want_selftest;
    if (bc_frame_corrupt) bad_frames <= bad_frames + 8'h01;
  end
endmodule : remote_ser_model
`default_nettype wire

// File: rx_equalizer_adapt_control_bench.sv
// Self-checking bench for the receive-port equalizer control
`timescale 1ns/10ps
`default_nettype none
module rx_equalizer_adapt_control_bench;
  import rx_eq_pkg::*;
  localparam int BASE = 4; // Short relock base keeps the run brief
  logic clk_sys = 1'h0;
  logic rstn = 1'h0;
  logic [7:0] reg_addr = 8'h00;
  logic [7:0] reg_wdata = 8'h00;
  logic reg_wr = 1'h0;
  logic bc_frame_start = 1'h0;
  logic want_lock = 1'h0;
  logic want_selftest = 1'h0;
  logic [7:0] reg_rdata;
  logic remote_selftest_in;
  logic cdr_lock_in;
  logic bc_frame_corrupt;
  logic [5:0] eq_select;
  logic adapt_done;
  logic rx_lock;
  logic [7:0] bad_frames;
  logic [7:0] rv;
  int err_count = 0;
  int tests_run = 0;
  int seed = 32'h9173;
  int steps;
  // Design and far side
  rx_equalizer_adapt_control #(.RELOCK_BASE_CYCLES(BASE)) DUT (.clk_sys(clk_sys), .rstn(rstn),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rdata(reg_rdata),
    .remote_selftest_in(remote_selftest_in), .cdr_lock_in(cdr_lock_in), .bc_frame_start(bc_frame_start),
    .bc_frame_corrupt(bc_frame_corrupt), .eq_select(eq_select), .adapt_done(adapt_done), .rx_lock(rx_lock));
  remote_ser_model u_ser (.clk_sys(clk_sys), .want_lock(want_lock), .want_selftest(want_selftest),
    .remote_selftest_in(remote_selftest_in), .cdr_lock_in(cdr_lock_in),
    .bc_frame_corrupt(bc_frame_corrupt), .bad_frames(bad_frames));
  // Clock
  initial begin
    forever #50 clk_sys = ~clk_sys;
  end
  task automatic give_verdict;
    $display("Comparisons %0d, mismatches %0d", tests_run, err_count);
    if (err_count == 0 && tests_run > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask : give_verdict
  task automatic cyc(input int n);
    repeat (n) @(posedge clk_sys);
    #1;
  endtask : cyc
  // Expected select in bypass: stage-one field on top, stage-two field below
  function automatic logic [5:0] manual_sel(input logic [7:0] v);
    return {v[BYP_UPPER_MSB:BYP_UPPER_LSB], v[BYP_LOWER_MSB:BYP_LOWER_LSB]};
  endfunction : manual_sel
  task automatic chk(input logic [15:0] got, input logic [15:0] exp, input string what);
    tests_run++;
    if (got !== exp) begin
      err_count++;
      $display("ERROR %0t %s: got %h want %h", $time, what, got, exp);
    end
  endtask : chk
  task automatic do_reset;
    rstn = 1'h0;
    want_lock = 1'h0;
    cyc(8);
    rstn = 1'h1;
    cyc(1);
  endtask : do_reset
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    reg_addr = a;
    reg_wdata = d;
    reg_wr = 1'h1;
    cyc(1);
    reg_wr = 1'h0;
    cyc(1);
  endtask : wr
  task automatic rdchk(input logic [7:0] a, input logic [7:0] m, input logic [7:0] e);
    reg_addr = a;
    cyc(1);
    chk({8'h00, reg_rdata & m}, {8'h00, e}, "register read");
  endtask : rdchk
  task automatic frame(input logic exp);
    bc_frame_start = 1'h1;
    cyc(1);
    bc_frame_start = 1'h0;
    chk({15'h0000, bc_frame_corrupt}, {15'h0000, exp}, "frame corruption");
    cyc(1);
  endtask : frame
  // Strict waits for the next change, otherwise for the value itself
  task automatic wait_sel(input logic [5:0] exp, input bit strict);
    logic [5:0] old;
    old = eq_select;
    steps = 0;
    while ((strict ? eq_select === old : eq_select !== exp) && steps < 2000) begin
      cyc(1);
      steps++;
    end
    if (steps >= 2000) begin
      err_count++;
      $display("ERROR %0t select never moved", $time);
      give_verdict();
    end else begin
      chk({10'h000, eq_select}, {10'h000, exp}, "select value");
    end
  endtask : wait_sel
  // Hang guard
  initial begin
    repeat (60000) @(posedge clk_sys);
    err_count++;
    $display("ERROR %0t run limit reached", $time);
    give_verdict();
  end
  // Main sequence
  initial begin
    do_reset();
    rdchk(ADDR_LINK_DEBUG, 8'hff, 8'h00);
    rdchk(ADDR_ADAPT_CTRL, 8'hff, 8'h80);
    rdchk(ADDR_BYPASS_SEL, 8'hff, 8'h60);
    rdchk(ADDR_EQ_LIMITS, 8'hff, 8'hf8);
    rdchk(8'hd1, 8'hff, 8'h00);
    $display("reset values done");
    wr(ADDR_LINK_DEBUG, 8'h01);
    rdchk(ADDR_LINK_DEBUG, 8'hff, 8'h01);
    frame(1'h1);
    frame(1'h0);
    rdchk(ADDR_LINK_DEBUG, 8'hff, 8'h00);
    wr(ADDR_LINK_DEBUG, 8'h02);
    repeat (3) frame(1'h1);
    wr(ADDR_LINK_DEBUG, 8'h00);
    frame(1'h0);
    chk({8'h00, bad_frames}, 16'h0004, "frames seen bad");
    $display("back channel done");
    want_selftest = 1'h1;
    cyc(4);
    rdchk(ADDR_LINK_DEBUG, 8'hff, 8'h20);
    wr(ADDR_LINK_DEBUG, 8'hdc);
    rdchk(ADDR_LINK_DEBUG, 8'hff, 8'hfc);
    want_selftest = 1'h0;
    cyc(4);
    rdchk(ADDR_LINK_DEBUG, 8'hff, 8'hdc);
    wr(ADDR_LINK_DEBUG, 8'h00);
    $display("self-test flag done");
    for (int c = 0; c < 8; c++) begin
      wr(ADDR_ADAPT_CTRL, 8'(c << 5) | 8'h08);
      wait_sel(6'h01, 1'h0);
      wait_sel(6'h02, 1'h1);
      chk(16'(steps), 16'(BASE << c), "relock interval");
    end
    $display("relock codes done");
    wr(ADDR_EQ_LIMITS, 8'h28);
    wr(ADDR_ADAPT_CTRL, 8'h08);
    wait_sel(6'h00, 1'h0);
    wait_sel(6'h01, 1'h1);
    wait_sel(6'h02, 1'h1);
    wait_sel(6'h00, 1'h1);
    wr(ADDR_EQ_LIMITS, 8'h75);
    wr(ADDR_ADAPT_CTRL, 8'h0c);
    wait_sel(6'h05, 1'h0);
    wait_sel(6'h06, 1'h1);
    wait_sel(6'h07, 1'h1);
    wait_sel(6'h05, 1'h1);
    $display("ceiling and floor done");
    for (int i = 0; i < 8; i++) begin
      rv = 8'($random(seed)) | 8'h01;
      wr(ADDR_BYPASS_SEL, rv);
      cyc(3);
      chk({10'h000, eq_select}, {10'h000, manual_sel(rv)}, "manual select");
      chk({15'h0000, adapt_done}, 16'h0001, "bypass done");
      rdchk(ADDR_EQ_STATUS, 8'hf8, 8'h00);
    end
    $display("bypass done");
    do_reset();
    wr(ADDR_BYPASS_SEL, 8'h70);
    wr(ADDR_ADAPT_CTRL, 8'h70);
    wait_sel(6'h02, 1'h0);
    want_lock = 1'h1;
    wait_sel(6'h00, 1'h1);
    cyc(8);
    chk({10'h000, eq_select}, 16'h0000, "first lock value");
    chk({14'h0000, adapt_done, rx_lock}, 16'h0003, "qualified lock");
    rdchk(ADDR_EQ_STATUS, 8'hf8, 8'h10);
    want_lock = 1'h0;
    cyc(6);
    chk({14'h0000, adapt_done, rx_lock}, 16'h0000, "lock lost");
    do_reset();
    wr(ADDR_ADAPT_CTRL, 8'h60);
    wait_sel(6'h03, 1'h0);
    want_lock = 1'h1;
    cyc(10);
    chk({8'h00, adapt_done, rx_lock, eq_select}, 16'h00c3, "lock at any value");
    wr(ADDR_ADAPT_CTRL, 8'h68);
    wait_sel(6'h00, 1'h1);
    rdchk(ADDR_ADAPT_CTRL, 8'hff, 8'h60);
    want_lock = 1'h0;
    $display("lock handling done");
    give_verdict();
  end
endmodule : rx_equalizer_adapt_control_bench
bind rx_equalizer_adapt_control rx_eq_checker #(.RELOCK_BASE_CYCLES(RELOCK_BASE_CYCLES)) u_chk (
  .clk_sys(clk_sys), .rstn(rstn), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
  .reg_rdata(reg_rdata), .remote_selftest_in(remote_selftest_in), .cdr_lock_in(cdr_lock_in),
  .bc_frame_start(bc_frame_start), .bc_frame_corrupt(bc_frame_corrupt), .eq_select(eq_select),
  .adapt_done(adapt_done), .rx_lock(rx_lock));
`default_nettype wire
